// file: hw/sbi_pkg.sv
// Constants for the host-side controller of a clockless SCSI interface chip.
// Assumes a 250 MHz system clock; times are converted to cycles here.
package sbi_pkg;
    // Clock rate used for time conversion
    localparam int CLK_MHZ = 250;
    // Least times, rounded up to whole cycles
    localparam int T_ARB_NS = 2200;
    localparam int T_EOP_NS = 100;
    localparam int T_RST_NS = 200;
    localparam int ARB_CYC = (T_ARB_NS * CLK_MHZ + 999) / 1000;
    localparam int EOP_CYC = (T_EOP_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_CYC = (T_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int CW = 10;
    // Chip ports
    localparam logic [2:0] P_MODE = 3'h2;
    localparam logic [2:0] P_LIVE = 3'h4;
    localparam logic [2:0] P_EVT = 3'h5;
    localparam logic [2:0] P_CLRIRQ = 3'h7;
    // Bits of the bus event status byte
    localparam int EV_DMA_DONE = 7;
    localparam int EV_PAR = 5;
    localparam int EV_IRQ = 4;
    localparam int EV_PHASE = 3;
    localparam int EV_BUSY = 2;
    // Bits of the live bus signal status byte
    localparam int LV_REQ = 5;
    localparam int LV_BSY = 6;
    localparam int LV_IO = 2;
    localparam int LV_SEL = 1;
    // Wishbone byte offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_RDATA = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_CAUSE = 8'h0c;
    localparam logic [7:0] A_ACT = 8'h10;
    // Command word fields
    localparam int CMD_WR = 11;
    localparam int CMD_GO = 12;
    // Action word fields
    localparam int ACT_RST = 0;
    localparam int ACT_EOP = 1;
    localparam int ACT_ARB = 2;
    localparam int ACT_AUTO = 3;
    // Cause register bits
    localparam int C_SEL = 0;
    localparam int C_RESEL = 1;
    localparam int C_EOP = 2;
    localparam int C_PAR = 3;
    localparam int C_PHASE = 4;
    localparam int C_BUSY = 5;
    localparam int C_BUSRST = 6;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STRB = 3'b010,
        ST_GAP = 3'b100
    } sbi_st_t;
endpackage

// file: hw/sbi_host.sv
// Host controller for a clockless SCSI interface chip: register access
// through the chip pins, interrupt service, end-of-process and reset pulses.
// Assumes the chip sees our strobes asynchronously and its answers are
// already synchronous to clk_i.
//
// Summary of operation
// - Software waits 2.2 us after arbitration start before checking.
// - Selection interrupt with I/O active counts as reselection.
// - Initiator receive: sample request and ack for more same-phase data.
// - Send: DMA-done is not bus completion; sample request and ack.
`timescale 1ns/1ps
`default_nettype none

module sbi_host #(
    parameter int ACC_CYC = 4,
    parameter int GAP_CYC = 2
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Chip register port
    output logic [2:0] dev_addr_o,
    output logic dev_cs_n_o,
    output logic dev_rd_n_o,
    output logic dev_wr_n_o,
    input wire logic [7:0] dev_data_i,
    output logic [7:0] dev_data_o,
    output logic dev_data_oe_o,
    // Chip control and DMA pins
    output logic dev_reset_n_o,
    input wire logic dev_irq_i,
    output logic dev_dma_ack_in_n_o,
    output logic dev_eop_n_o
);
    sbi_pkg::sbi_st_t st_r;
    logic [sbi_pkg::CW-1:0] cnt_r;
    logic [sbi_pkg::CW-1:0] eop_cnt_r;
    logic [sbi_pkg::CW-1:0] rst_cnt_r;
    logic [sbi_pkg::CW-1:0] arb_cnt_r;
    logic arb_done_r;
    logic [1:0] svc_r;
    logic wr_r;
    logic auto_r;
    logic [7:0] rdata_r;
    logic [7:0] evt_r;
    logic [7:0] live_r;
    logic [6:0] cause_r;
    logic [31:0] dat_r;
    logic ack_r;

    // Bus request decode
    wire req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wreq = req & wb_we_i & wb_sel_i[0];
    wire idle = st_r == sbi_pkg::ST_IDLE;
    wire eop_busy = eop_cnt_r != '0;
    wire rst_busy = rst_cnt_r != '0;
    wire free = idle & ~eop_busy & ~rst_busy;
    wire go_sw = wreq & (wb_adr_i == sbi_pkg::A_CMD) & wb_dat_i[sbi_pkg::CMD_GO]
        & free & (svc_r == 2'd0);
    wire wr_act = wreq & (wb_adr_i == sbi_pkg::A_ACT);
    // Chip reset and end-of-process only start with the port quiet
    wire go_rst = wr_act & wb_dat_i[sbi_pkg::ACT_RST] & free;
    wire go_eop = wr_act & wb_dat_i[sbi_pkg::ACT_EOP] & free & ~go_rst;
    wire go_arb = wr_act & wb_dat_i[sbi_pkg::ACT_ARB];
    // Service starts only when software is not starting an access, chip reset or end-of-process itself
    wire go_svc = auto_r & dev_irq_i & free & (svc_r == 2'd0)
        & ~go_sw & ~go_rst & ~go_eop;
    wire strb_end = (st_r == sbi_pkg::ST_STRB)
        & (cnt_r == sbi_pkg::CW'(ACC_CYC - 1));
    wire gap_end = (st_r == sbi_pkg::ST_GAP)
        & (cnt_r == sbi_pkg::CW'(GAP_CYC - 1));
    wire svc_next = gap_end & (svc_r != 2'd0) & (svc_r != 2'd3);
    wire [2:0] svc_port = (svc_r == 2'd1) ? sbi_pkg::P_LIVE
        : sbi_pkg::P_CLRIRQ;

    // Cause decode from the two status snapshots
    wire sel_hit = evt_r[sbi_pkg::EV_IRQ] & live_r[sbi_pkg::LV_SEL];
    wire c_sel = sel_hit & ~live_r[sbi_pkg::LV_IO];
    wire c_resel = sel_hit & live_r[sbi_pkg::LV_IO];
    wire c_eop = evt_r[sbi_pkg::EV_DMA_DONE];
    wire c_par = evt_r[sbi_pkg::EV_PAR] & ~sel_hit;
    wire c_busy = evt_r[sbi_pkg::EV_BUSY];
    wire c_phase = ~evt_r[sbi_pkg::EV_PHASE] & live_r[sbi_pkg::LV_BSY]
        & ~c_eop & ~c_busy & ~c_par & ~sel_hit;
    // Bus reset is the cause when nothing else explains the interrupt
    wire c_rst = ~(sel_hit | c_eop | c_par | c_busy | c_phase);
    wire [6:0] cause_new = {c_rst, c_busy, c_phase, c_par, c_eop, c_resel,
        c_sel};
    wire cause_set = gap_end & (svc_r == 2'd3);
    wire cause_clr = wreq & (wb_adr_i == sbi_pkg::A_CAUSE);

    // Read mux; unmapped offsets read zero
    wire [31:0] rd_mux =
        (wb_adr_i == sbi_pkg::A_RDATA) ? {8'h00, live_r, evt_r, rdata_r} :
        (wb_adr_i == sbi_pkg::A_STAT) ? {26'h0, arb_done_r, rst_busy,
            eop_busy, dev_irq_i, svc_r != 2'd0, ~idle} :
        (wb_adr_i == sbi_pkg::A_CAUSE) ? {25'h0, cause_r} :
        (wb_adr_i == sbi_pkg::A_ACT) ? {28'h0, auto_r, 3'h0} : 32'h0;

    // Wishbone answer one cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            auto_r <= 1'b0;
        end
        else if (ce_i)
        begin
            ack_r <= req;
            if (req)
                dat_r <= rd_mux;
            if (wr_act)
                auto_r <= wb_dat_i[sbi_pkg::ACT_AUTO];
        end
    end

    // Access sequencer: strobe phase, then recovery gap
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= sbi_pkg::ST_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            dev_addr_o <= 3'h0;
            dev_data_o <= 8'h00;
        end
        else if (ce_i)
        begin
            if (go_sw)
            begin
                st_r <= sbi_pkg::ST_STRB;
                wr_r <= wb_dat_i[sbi_pkg::CMD_WR];
                dev_addr_o <= wb_dat_i[10:8];
                dev_data_o <= wb_dat_i[7:0];
                cnt_r <= '0;
            end
            else if (go_svc | svc_next)
            begin
                st_r <= sbi_pkg::ST_STRB;
                wr_r <= 1'b0;
                dev_addr_o <= go_svc ? sbi_pkg::P_EVT : svc_port;
                cnt_r <= '0;
            end
            else if (strb_end)
            begin
                st_r <= sbi_pkg::ST_GAP;
                cnt_r <= '0;
            end
            else if (gap_end)
                st_r <= sbi_pkg::ST_IDLE;
            else if (!idle)
                cnt_r <= cnt_r + 1'b1;
        end
    end

    // Chip strobes; chip select never overlaps the DMA acknowledge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dev_cs_n_o <= 1'b1;
            dev_rd_n_o <= 1'b1;
            dev_wr_n_o <= 1'b1;
            dev_data_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (go_sw | go_svc | svc_next)
            begin
                dev_cs_n_o <= 1'b0;
                dev_rd_n_o <= go_sw & wb_dat_i[sbi_pkg::CMD_WR];
                dev_wr_n_o <= ~(go_sw & wb_dat_i[sbi_pkg::CMD_WR]);
                dev_data_oe_o <= go_sw & wb_dat_i[sbi_pkg::CMD_WR];
            end
            else if (go_eop)
                dev_rd_n_o <= 1'b0;
            else if (strb_end | (eop_cnt_r == sbi_pkg::CW'(1)))
            begin
                dev_cs_n_o <= 1'b1;
                dev_rd_n_o <= 1'b1;
                dev_wr_n_o <= 1'b1;
                dev_data_oe_o <= 1'b0;
            end
        end
    end

    // Read capture; a port 7 read clears the chip interrupt
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_r <= 8'h00;
            evt_r <= 8'h00;
            live_r <= 8'h00;
            svc_r <= 2'd0;
        end
        else if (ce_i)
        begin
            if (strb_end & ~wr_r)
            begin
                rdata_r <= dev_data_i;
                // Snapshots keep request and ack for completion polling
                if (svc_r == 2'd1)
                    evt_r <= dev_data_i;
                if (svc_r == 2'd2)
                    live_r <= dev_data_i;
            end
            if (go_svc)
                svc_r <= 2'd1;
            else if (gap_end & (svc_r != 2'd0))
                svc_r <= (svc_r == 2'd3) ? 2'd0 : svc_r + 2'd1;
        end
    end

    // Sticky causes; a new cause wins over a same-cycle clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cause_r <= 7'h00;
        else if (ce_i)
            cause_r <= (cause_r & ~(cause_clr ? wb_dat_i[6:0] : 7'h00))
                | (cause_set ? cause_new : 7'h00);
    end

    // End-of-process pulse with ack and read strobe, at least 100 ns
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            eop_cnt_r <= '0;
            dev_eop_n_o <= 1'b1;
            dev_dma_ack_in_n_o <= 1'b1;
        end
        else if (ce_i)
        begin
            if (go_eop)
            begin
                eop_cnt_r <= sbi_pkg::CW'(sbi_pkg::EOP_CYC);
                dev_eop_n_o <= 1'b0;
                dev_dma_ack_in_n_o <= 1'b0;
            end
            else if (eop_busy)
            begin
                eop_cnt_r <= eop_cnt_r - 1'b1;
                if (eop_cnt_r == sbi_pkg::CW'(1))
                begin
                    dev_eop_n_o <= 1'b1;
                    dev_dma_ack_in_n_o <= 1'b1;
                end
            end
        end
    end

    // Chip reset pulse, also clears the chip interrupt
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rst_cnt_r <= '0;
            dev_reset_n_o <= 1'b1;
        end
        else if (ce_i)
        begin
            if (go_rst)
            begin
                rst_cnt_r <= sbi_pkg::CW'(sbi_pkg::RST_CYC);
                dev_reset_n_o <= 1'b0;
            end
            else if (rst_busy)
            begin
                rst_cnt_r <= rst_cnt_r - 1'b1;
                dev_reset_n_o <= rst_cnt_r == sbi_pkg::CW'(1);
            end
        end
    end

    // Arbitration settle timer; the chip itself does not time it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            arb_cnt_r <= '0;
            arb_done_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (go_arb)
            begin
                arb_cnt_r <= sbi_pkg::CW'(sbi_pkg::ARB_CYC);
                arb_done_r <= 1'b0;
            end
            else if (arb_cnt_r != '0)
            begin
                arb_cnt_r <= arb_cnt_r - 1'b1;
                arb_done_r <= arb_cnt_r == sbi_pkg::CW'(1);
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
endmodule

`default_nettype wire

// file: tb/sbi_host_assertions.sv
// Checker of the host controller's pin and bus timing.
// Sees only the top ports; bound into sbi_host below.
`timescale 1ns/1ps
`default_nettype none
module sbi_chk #(
    parameter int ACC_CYC = 4,
    parameter int GAP_CYC = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Chip pins
    input wire logic [2:0] dev_addr_o,
    input wire logic dev_cs_n_o,
    input wire logic dev_rd_n_o,
    input wire logic dev_wr_n_o,
    input wire logic [7:0] dev_data_o,
    input wire logic dev_data_oe_o,
    input wire logic dev_reset_n_o,
    input wire logic dev_dma_ack_in_n_o,
    input wire logic dev_eop_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Low run lengths, judged when the pin rises again
    logic [9:0] eop_run_r;
    logic [9:0] rst_run_r;
    logic [9:0] cs_run_r;
    wire eop_all = !dev_eop_n_o && !dev_dma_ack_in_n_o && !dev_rd_n_o;
    always_ff @(posedge clk_i)
    begin
        eop_run_r <= eop_all ? eop_run_r + 10'h1 : 10'h0;
        rst_run_r <= dev_reset_n_o ? 10'h0 : rst_run_r + 10'h1;
        cs_run_r <= dev_cs_n_o ? 10'h0 : cs_run_r + 10'h1;
    end
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_eop_width: assert property ($rose(dev_eop_n_o) |-> eop_run_r >= sbi_pkg::EOP_CYC)
        else $error("end of process overlap too short");
    a_dma_ack_in_no_cs: assert property (!dev_dma_ack_in_n_o |-> dev_cs_n_o && dev_wr_n_o)
        else $error("dma ack together with chip select");
    a_reset_width: assert property ($rose(dev_reset_n_o) |-> rst_run_r >= sbi_pkg::RST_CYC)
        else $error("chip reset pulse too short");
    a_cs_width: assert property ($rose(dev_cs_n_o) |-> cs_run_r == ACC_CYC)
        else $error("chip access of wrong length");
    a_gap_idle: assert property ($rose(dev_cs_n_o) |-> dev_cs_n_o [*2])
        else $error("recovery gap cut short");
    a_write_cs: assert property (!dev_wr_n_o |-> !dev_cs_n_o && dev_rd_n_o)
        else $error("write strobe without select");
    a_oe_write: assert property (dev_data_oe_o == !dev_wr_n_o)
        else $error("data drive not matching write strobe");
    a_addr_hold: assert property (!dev_cs_n_o && !$past(dev_cs_n_o)
        |-> $stable(dev_addr_o) && $stable(dev_data_o))
        else $error("address or data moved during access");
    c_eop: cover property ($rose(dev_eop_n_o));
    c_reset: cover property ($rose(dev_reset_n_o));
    c_write: cover property ($fell(dev_wr_n_o));
endmodule

bind sbi_host sbi_chk #(.ACC_CYC(ACC_CYC), .GAP_CYC(GAP_CYC)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dev_addr_o(dev_addr_o),
    .dev_cs_n_o(dev_cs_n_o), .dev_rd_n_o(dev_rd_n_o),
    .dev_wr_n_o(dev_wr_n_o), .dev_data_o(dev_data_o),
    .dev_data_oe_o(dev_data_oe_o), .dev_reset_n_o(dev_reset_n_o),
    .dev_dma_ack_in_n_o(dev_dma_ack_in_n_o), .dev_eop_n_o(dev_eop_n_o));
`default_nettype wire

// file: tb/sbi_chip_model.sv
// Behavioural model of the interface chip seen from its host pins.
// Bus busy is taken as long released, so the bus counts as free.
`timescale 1ns/1ps
`default_nettype none
module sbi_chip_model (
    // Host pins
    input wire logic clk_i,
    input wire logic [2:0] addr_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_i,
    input wire logic reset_n_i,
    input wire logic dma_ack_in_n_i,
    input wire logic eop_n_i,
    output logic [7:0] data_o,
    output logic irq_o,
    // Far bus lines
    input wire logic bus_rst_i,
    input wire logic bus_sel_i,
    input wire logic bus_io_i
);
    logic [7:0] mode_r = 8'h00, selen_r = 8'h00, last_r = 8'h00;
    logic irq_r = 1'b0, dma_r = 1'b0, cs_q = 1'b1, rd_q = 1'b1;
    logic rst_q = 1'b0, hit_q = 1'b0;
    logic [9:0] eop_r = 10'h0, hrst_r = 10'h0;
    // Decodes; an unselected bus shows a changing pattern, not old data
    wire rd_on = !cs_n_i && !rd_n_i;
    wire wr_on = !cs_n_i && !wr_n_i;
    wire hit = bus_sel_i && |selen_r;
    wire eop_on = !eop_n_i && !dma_ack_in_n_i && (!rd_n_i || !wr_n_i);
    wire eop_hit = eop_on && mode_r[1] && eop_r == sbi_pkg::EOP_CYC - 1;
    wire [7:0] live = {bus_rst_i, 4'h0, bus_io_i, bus_sel_i, 1'b0};
    wire [7:0] evt = {dma_r, 2'b00, irq_r, 4'h0};
    assign data_o = rd_on ? (addr_i == 3'h4 ? live : evt) : ~last_r;
    assign irq_o = irq_r;
    // Register writes, interrupt latch and the reset filter
    always_ff @(posedge clk_i)
    begin
        last_r <= data_o;
        cs_q <= cs_n_i;
        rd_q <= rd_n_i;
        rst_q <= bus_rst_i;
        hit_q <= hit;
        hrst_r <= reset_n_i ? 10'h0 : hrst_r + 10'h1;
        eop_r <= eop_on ? eop_r + 10'h1 : 10'h0;
        if (wr_on && addr_i == 3'h2)
            mode_r <= data_i;
        if (wr_on && addr_i == 3'h4)
            selen_r <= data_i;
        if (!mode_r[1])
            dma_r <= 1'b0;
        if (eop_hit)
            dma_r <= 1'b1;
        if (eop_hit && mode_r[3])
            irq_r <= 1'b1;
        if (hit && !hit_q)
            irq_r <= 1'b1;
        if (bus_rst_i && !rst_q || wr_on && addr_i == 3'h1 && data_i[7])
            irq_r <= 1'b1;
        if (rd_n_i && !rd_q && !cs_q && addr_i == 3'h7)
            irq_r <= 1'b0;
        // Short reset glitches are ignored, a full one clears all
        if (!reset_n_i && hrst_r >= sbi_pkg::RST_CYC - 1)
        begin
            mode_r <= 8'h00;
            selen_r <= 8'h00;
            irq_r <= 1'b0;
            dma_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: tb/sbi_host_bench.sv
// Self-checking bench of the host controller with a chip model.
// Wishbone master tasks; the checker is bound in separately.
`timescale 1ns/1ps
`default_nettype none
module sbi_host_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, bus_rst = 1'b0, bus_sel = 1'b0, bus_io = 1'b0;
    logic ce_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, dev_cs_n_o, dev_rd_n_o, dev_wr_n_o, dev_data_oe_o;
    logic dev_reset_n_o, dev_irq_i, dev_dma_ack_in_n_o, dev_eop_n_o;
    logic [2:0] dev_addr_o;
    logic [7:0] dev_data_i, dev_data_o;
    int error_cnt = 0, cmp_count = 0;
    always #2 clk_i = ~clk_i;
    sbi_host dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_addr_o(dev_addr_o),
        .dev_cs_n_o(dev_cs_n_o), .dev_rd_n_o(dev_rd_n_o),
        .dev_wr_n_o(dev_wr_n_o), .dev_data_i(dev_data_i),
        .dev_data_o(dev_data_o), .dev_data_oe_o(dev_data_oe_o),
        .dev_reset_n_o(dev_reset_n_o), .dev_irq_i(dev_irq_i),
        .dev_dma_ack_in_n_o(dev_dma_ack_in_n_o), .dev_eop_n_o(dev_eop_n_o));
    sbi_chip_model chip (.clk_i(clk_i), .addr_i(dev_addr_o),
        .cs_n_i(dev_cs_n_o), .rd_n_i(dev_rd_n_o), .wr_n_i(dev_wr_n_o),
        .data_i(dev_data_o), .reset_n_i(dev_reset_n_o),
        .dma_ack_in_n_i(dev_dma_ack_in_n_o), .eop_n_i(dev_eop_n_o),
        .data_o(dev_data_i), .irq_o(dev_irq_i), .bus_rst_i(bus_rst),
        .bus_sel_i(bus_sel), .bus_io_i(bus_io));
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One classic cycle; request held until ack is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    // Polls a register until the masked value matches, then compares
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e, input int lim);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, a, 32'h0, q);
            n++;
        end
        while ((q & m) !== e && n < lim);
        chk(q & m, e);
    endtask
    // Chip port access; the gap wait lets the sequencer take the next go
    task automatic cmd(input logic [2:0] p, input logic [7:0] d,
        input logic w);
        wr(sbi_pkg::A_CMD, {19'h0, 1'b1, w, p, d});
        expect_rd(sbi_pkg::A_STAT, 32'h1, 32'h0, 200);
        repeat (2) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_of_test;
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        expect_rd(sbi_pkg::A_STAT, 32'h3f, 32'h0, 1);
        expect_rd(sbi_pkg::A_CAUSE, 32'h7f, 32'h0, 1);
        expect_rd(8'hfc, 32'hffffffff, 32'h0, 1);
        wr(sbi_pkg::A_ACT, 32'h4);
        expect_rd(sbi_pkg::A_STAT, 32'h20, 32'h0, 1);
        // Enable low must freeze the settle timer past its full span
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (600) @(posedge clk_i);
        ce_i <= 1'b1;
        expect_rd(sbi_pkg::A_STAT, 32'h20, 32'h0, 1);
        expect_rd(sbi_pkg::A_STAT, 32'h20, 32'h20, 400);
        // End of process with its interrupt enabled, then disabled
        for (int en = 1; en >= 0; en--)
        begin
            cmd(3'h2, 8'h00, 1'b1);
            cmd(3'h2, {4'h0, en[0], 3'h2}, 1'b1);
            wr(sbi_pkg::A_ACT, 32'h2);
            expect_rd(sbi_pkg::A_STAT, 32'h8, 32'h0, 100);
            expect_rd(sbi_pkg::A_STAT, 32'h4, {29'h0, en[0], 2'h0}, 1);
            cmd(3'h5, 8'h00, 1'b0);
            expect_rd(sbi_pkg::A_RDATA, 32'hff, {24'h0, 3'h4, en[0], 4'h0}, 1);
            cmd(3'h7, 8'h00, 1'b0);
            expect_rd(sbi_pkg::A_STAT, 32'h4, 32'h0, 1);
        end
        // Bus reset interrupt, removed by a chip reset pulse
        bus_rst <= 1'b1;
        expect_rd(sbi_pkg::A_STAT, 32'h4, 32'h4, 20);
        bus_rst <= 1'b0;
        wr(sbi_pkg::A_ACT, 32'h1);
        expect_rd(sbi_pkg::A_STAT, 32'h10, 32'h0, 100);
        expect_rd(sbi_pkg::A_STAT, 32'h4, 32'h0, 1);
        // Software bus reset, found by default in automatic service
        cmd(3'h1, 8'h80, 1'b1);
        expect_rd(sbi_pkg::A_STAT, 32'h4, 32'h4, 1);
        wr(sbi_pkg::A_ACT, 32'h8);
        expect_rd(sbi_pkg::A_CAUSE, 32'h7f, 32'h40, 100);
        wr(sbi_pkg::A_CAUSE, 32'h7f);
        expect_rd(sbi_pkg::A_CAUSE, 32'h7f, 32'h0, 1);
        // Selection, reselection, then an all-zero mask
        cmd(3'h4, 8'h01, 1'b1);
        for (int io = 0; io < 2; io++)
        begin
            bus_io <= io[0];
            bus_sel <= 1'b1;
            expect_rd(sbi_pkg::A_CAUSE, 32'h1 << io, 32'h1 << io, 200);
            expect_rd(sbi_pkg::A_STAT, 32'h6, 32'h0, 100);
            bus_sel <= 1'b0;
            wr(sbi_pkg::A_CAUSE, 32'h7f);
        end
        cmd(3'h4, 8'h00, 1'b1);
        bus_sel <= 1'b1;
        repeat (50) @(posedge clk_i);
        expect_rd(sbi_pkg::A_CAUSE, 32'h7f, 32'h0, 1);
        end_of_test;
    end
endmodule
`default_nettype wire
